// *** common/brc_consts.svh ***
// offsets, field positions, reset values and timing counts for the board control registers
//
// Contract
// - reset configuration register is one byte at I/O 2A0H, bits 0 and 4.
// - bit 0 clear: backplane system reset does not reset the board.
// - bit 0 set: backplane reset signal resets the board.
// - bit 4 set: panel switch resets board and drives backplane reset.
// - bit 4 clear: panel switch resets only the board.
// - reserved bits read as anything; host writes back what it read.
// - rom and board options register is one byte at I/O 2A1H.
// - options bit 0 enables the on-board scsi terminators.
// - options bit 1 picks com2 driver: set rs422, clear rs232.
// - options bit 5 gates on-board flash writes; clear means read-only.
// - options bit 6 gates socket flash writes; clear means read-only.
// - options bit 7 routes boot chip select; loaded from jumper at reset.
`ifndef BRC_CONSTS_SVH
`define BRC_CONSTS_SVH

// ----------------------------------------------------------------------------
// addresses and fields
// ----------------------------------------------------------------------------
`define BRC_ADDR_RESET_CFG 10'h2a0
`define BRC_ADDR_ROM_OPTS 10'h2a1
`define BRC_BIT_BACKPLANE_RESET_ACCEPT 0
`define BRC_BIT_PANEL_RESET_TO_BACKPLANE 4
`define BRC_BIT_SCSI_TERMINATOR_ENABLE 0
`define BRC_BIT_COM2_DRIVER_SELECT 1
`define BRC_BIT_ONBOARD_FLASH_WE 5
`define BRC_BIT_SOCKET_FLASH_WE 6
`define BRC_BIT_BOOT_ROM_CS 7

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define BRC_RST_BACKPLANE_RESET_ACCEPT 1'b1
`define BRC_RST_PANEL_RESET_TO_BACKPLANE 1'b0
`define BRC_RST_SCSI_TERMINATOR_ENABLE 1'b1
`define BRC_RST_COM2_DRIVER_SELECT 1'b0
`define BRC_RESERVED_READ 8'h00
`define BRC_RESET_PULSE_CYCLES 8

`endif

// *** common/brc_pkg.sv ***
// types shared by the board control register files
package brc_pkg;
  // register selected by the current i/o access
  typedef enum logic [1:0] {
    brc_sel_none,
    brc_sel_reset_cfg,
    brc_sel_rom_opts
  } brc_sel_type;
endpackage

// *** common/brc_sync_if.sv ***
// interface carrying a raw pin level into a synchroniser and the clean level out
`timescale 1ns/100ps
interface brc_sync_if;
  logic raw;
  logic clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// *** design/brc_sync.sv ***
// two-flop synchroniser for one asynchronous pin level
`timescale 1ns/100ps
module brc_sync #(
  parameter logic INIT = 1'b0 // level held during reset
) (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous active high reset
  brc_sync_if.sync port // raw in, clean out
);
  logic stage1;
  logic stage2;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= INIT;
      stage2 <= INIT;
    end else begin
      stage1 <= port.raw;
      stage2 <= stage1;
    end
  end

  assign port.clean = stage2;
endmodule

// *** design/brc_regs.sv ***
// board reset and boot rom control registers on the isa i/o bus
`timescale 1ns/100ps
`include "brc_consts.svh"
module brc_regs #(
  parameter int ADDR_W = 10, // isa i/o address bits decoded
  parameter int RESET_PULSE_CYCLES = `BRC_RESET_PULSE_CYCLES // length of generated reset pulses
) (
  input wire logic clk, // 100 mhz local clock
  input wire logic reset, // board reset, sync, active high
  input wire logic [ADDR_W-1:0] io_addr, // i/o address
  input wire logic io_wr, // one-cycle write strobe
  input wire logic io_rd, // one-cycle read strobe
  input wire logic [7:0] io_wdata, // write data
  output logic [7:0] io_rdata, // read data, valid cycle after io_rd
  input wire logic backplane_sysreset_in, // vme system reset seen, active high, async
  input wire logic panel_switch_in, // front panel reset pressed, active high, async
  input wire logic boot_jumper_installed, // boot select jumper installed, async
  output logic board_reset_req, // pulse request to reset this board
  output logic backplane_sysreset_out, // drive vme system reset
  output logic scsi_terminator_enable, // active terminators on
  output logic com2_driver_select, // 1 rs422, 0 rs232
  output logic onboard_flash_write_enable, // on-board flash writable
  output logic socket_flash_write_enable, // socket flash writable
  output logic boot_rom_chip_select // 1 on-board flash, 0 socket
);
  // refuse widths the decoder and the 8-bit pulse counters cannot serve
  if (ADDR_W < 10 || RESET_PULSE_CYCLES < 1 || RESET_PULSE_CYCLES > 255) begin : g_bad_params
    $error("brc_regs: unsupported parameter values");
  end

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  brc_sync_if bp_if ();
  brc_sync_if pn_if ();
  brc_sync_if jp_if ();
  assign bp_if.raw = backplane_sysreset_in;
  assign pn_if.raw = panel_switch_in;
  assign jp_if.raw = boot_jumper_installed;
  brc_sync #(.INIT(1'b0)) u_sync_bp (.clk(clk), .reset(reset), .port(bp_if));
  brc_sync #(.INIT(1'b0)) u_sync_pn (.clk(clk), .reset(reset), .port(pn_if));
  brc_sync #(.INIT(1'b0)) u_sync_jp (.clk(clk), .reset(reset), .port(jp_if));

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  brc_pkg::brc_sel_type sel;
  always_comb begin
    if (io_addr == ADDR_W'(`BRC_ADDR_RESET_CFG)) begin
      sel = brc_pkg::brc_sel_reset_cfg;
    end else if (io_addr == ADDR_W'(`BRC_ADDR_ROM_OPTS)) begin
      sel = brc_pkg::brc_sel_rom_opts;
    end else begin
      sel = brc_pkg::brc_sel_none;
    end
  end

  // --------------------------------------------------------------------------
  // reset configuration register
  // --------------------------------------------------------------------------
  logic backplane_reset_accept;
  logic panel_reset_to_backplane;

  // only the two defined bits are stored; reserved bits are dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      backplane_reset_accept <= `BRC_RST_BACKPLANE_RESET_ACCEPT;
      panel_reset_to_backplane <= `BRC_RST_PANEL_RESET_TO_BACKPLANE;
    end else if (io_wr && sel == brc_pkg::brc_sel_reset_cfg) begin
      backplane_reset_accept <= io_wdata[`BRC_BIT_BACKPLANE_RESET_ACCEPT];
      panel_reset_to_backplane <= io_wdata[`BRC_BIT_PANEL_RESET_TO_BACKPLANE];
    end
  end

  // --------------------------------------------------------------------------
  // rom and board options register
  // --------------------------------------------------------------------------
  logic [1:0] jumper_wait;
  logic jumper_loaded;
  assign jumper_loaded = (jumper_wait == 2'h3);

  // the synchroniser is cleared by reset too, so the jumper is read only at the third edge,
  // once both stages hold the real pin; bit 7 writes are refused until then
  always_ff @(posedge clk) begin
    if (reset) begin
      jumper_wait <= 2'h0;
      boot_rom_chip_select <= 1'b1;
    end else if (!jumper_loaded) begin
      jumper_wait <= jumper_wait + 2'h1;
      if (jumper_wait == 2'h2) begin
        boot_rom_chip_select <= ~jp_if.clean;
      end
    end else if (io_wr && sel == brc_pkg::brc_sel_rom_opts) begin
      boot_rom_chip_select <= io_wdata[`BRC_BIT_BOOT_ROM_CS];
    end
  end

  // options bits steer the board straight from the flops
  always_ff @(posedge clk) begin
    if (reset) begin
      scsi_terminator_enable <= `BRC_RST_SCSI_TERMINATOR_ENABLE;
      com2_driver_select <= `BRC_RST_COM2_DRIVER_SELECT;
      onboard_flash_write_enable <= 1'b0;
      socket_flash_write_enable <= 1'b0;
    end else if (io_wr && sel == brc_pkg::brc_sel_rom_opts) begin
      scsi_terminator_enable <= io_wdata[`BRC_BIT_SCSI_TERMINATOR_ENABLE];
      com2_driver_select <= io_wdata[`BRC_BIT_COM2_DRIVER_SELECT];
      onboard_flash_write_enable <= io_wdata[`BRC_BIT_ONBOARD_FLASH_WE];
      socket_flash_write_enable <= io_wdata[`BRC_BIT_SOCKET_FLASH_WE];
    end
  end

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = `BRC_RESERVED_READ;
    case (sel)
      brc_pkg::brc_sel_reset_cfg: begin
        next_rdata[`BRC_BIT_BACKPLANE_RESET_ACCEPT] = backplane_reset_accept;
        next_rdata[`BRC_BIT_PANEL_RESET_TO_BACKPLANE] = panel_reset_to_backplane;
      end
      brc_pkg::brc_sel_rom_opts: begin
        next_rdata[`BRC_BIT_SCSI_TERMINATOR_ENABLE] = scsi_terminator_enable;
        next_rdata[`BRC_BIT_COM2_DRIVER_SELECT] = com2_driver_select;
        next_rdata[`BRC_BIT_ONBOARD_FLASH_WE] = onboard_flash_write_enable;
        next_rdata[`BRC_BIT_SOCKET_FLASH_WE] = socket_flash_write_enable;
        next_rdata[`BRC_BIT_BOOT_ROM_CS] = boot_rom_chip_select;
      end
      default: begin
        next_rdata = `BRC_RESERVED_READ;
      end
    endcase
  end

  // read data registered; unmapped reads answer zero
  always_ff @(posedge clk) begin
    if (reset) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      io_rdata <= next_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // reset sources
  // --------------------------------------------------------------------------
  logic bp_prev;
  logic pn_prev;
  logic bp_rise;
  logic pn_rise;
  logic [7:0] board_cnt;
  logic [7:0] bus_cnt;

  // edges on the clean levels; the board reset pulse would otherwise retrigger
  always_ff @(posedge clk) begin
    if (reset) begin
      bp_prev <= 1'b0;
      pn_prev <= 1'b0;
    end else begin
      bp_prev <= bp_if.clean;
      pn_prev <= pn_if.clean;
    end
  end
  assign bp_rise = bp_if.clean && !bp_prev;
  assign pn_rise = pn_if.clean && !pn_prev;

  // board reset request: panel always, backplane only when accepted
  always_ff @(posedge clk) begin
    if (reset) begin
      board_cnt <= 8'h00;
      board_reset_req <= 1'b0;
    end else if (pn_rise || (bp_rise && backplane_reset_accept)) begin
      board_cnt <= 8'(RESET_PULSE_CYCLES - 1);
      board_reset_req <= 1'b1;
    end else if (board_cnt != 8'h00) begin
      board_cnt <= board_cnt - 8'h01;
    end else begin
      board_reset_req <= 1'b0;
    end
  end

  // backplane reset out only from the panel, when forwarding is on
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_cnt <= 8'h00;
      backplane_sysreset_out <= 1'b0;
    end else if (pn_rise && panel_reset_to_backplane) begin
      bus_cnt <= 8'(RESET_PULSE_CYCLES - 1);
      backplane_sysreset_out <= 1'b1;
    end else if (bus_cnt != 8'h00) begin
      bus_cnt <= bus_cnt - 8'h01;
    end else begin
      backplane_sysreset_out <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_bp_ignored: assert property ((bp_rise && !backplane_reset_accept && !pn_rise) |=>
    !$rose(board_reset_req)) else $error("backplane reset taken while ignored");
  a_bp_accepted: assert property ((bp_rise && backplane_reset_accept) |=>
    board_reset_req) else $error("accepted backplane reset lost");
  a_panel_fwd: assert property ((pn_rise && panel_reset_to_backplane) |=>
    (board_reset_req && backplane_sysreset_out)) else $error("panel reset not forwarded");
  a_panel_local: assert property ((pn_rise && !panel_reset_to_backplane && !backplane_sysreset_out) |=>
    (board_reset_req && !backplane_sysreset_out)) else $error("panel reset leaked to backplane");
  a_cfg_write: assert property ((io_wr && io_addr == ADDR_W'(`BRC_ADDR_RESET_CFG)) |=>
    backplane_reset_accept == $past(io_wdata[0])) else $error("reset config write lost");
  a_term_write: assert property ((io_wr && io_addr == ADDR_W'(`BRC_ADDR_ROM_OPTS) && jumper_loaded) |=>
    (scsi_terminator_enable == $past(io_wdata[0]) && com2_driver_select == $past(io_wdata[1])))
    else $error("options write lost");
  a_flash_hold: assert property ((!(io_wr && sel == brc_pkg::brc_sel_rom_opts)) |=>
    ($stable(onboard_flash_write_enable) && $stable(socket_flash_write_enable)))
    else $error("flash enable changed without write");
  a_flash_reset: assert property (@(posedge clk) disable iff (1'b0) reset |=>
    (!onboard_flash_write_enable && !socket_flash_write_enable)) else $error("flash enable set after reset");
  a_read_back: assert property ((io_rd && sel == brc_pkg::brc_sel_rom_opts) |=>
    io_rdata[7:5] == $past({boot_rom_chip_select, socket_flash_write_enable, onboard_flash_write_enable}))
    else $error("options readback wrong");
  a_pulse_len: assert property ($rose(board_reset_req) |-> board_reset_req [*2])
    else $error("board reset pulse too short");
  a_jumper_load: assert property ((jumper_wait == 2'h2) |=>
    boot_rom_chip_select == !$past(jp_if.clean)) else $error("boot select not loaded from jumper");

  c_bp_reset: cover property (bp_rise && backplane_reset_accept);
  c_panel_fwd: cover property (pn_rise && panel_reset_to_backplane);
  c_flash_on: cover property ($rose(onboard_flash_write_enable));
  c_jumper_in: cover property ($fell(boot_rom_chip_select));
endmodule

// *** test/brc_host_model.sv ***
// host-side model of the isa i/o master reaching the board control registers
`timescale 1ns/100ps
module brc_host_model (
  output logic [9:0] io_addr, // i/o address
  output logic io_wr, // write strobe
  output logic io_rd, // read strobe
  output logic [7:0] io_wdata, // write data
  input wire logic clk, // system clock
  input wire logic [7:0] io_rdata // registered read data
);
  // --------------------------------------------------------------------------
  // bus cycles
  // --------------------------------------------------------------------------
  // quiet bus at time zero
  initial begin
    io_addr = 10'h000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // one strobe per access; released lines show inverted leftovers, not the last value
  task automatic cycle(input logic [9:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = w;
    io_rd = !w;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask

  task automatic io_write(input logic [9:0] a, input logic [7:0] d);
    cycle(a, 1'b1, d);
  endtask

  // read data is registered at the strobe's edge, so it is taken just after it
  task automatic io_read(input logic [9:0] a, output logic [7:0] d);
    cycle(a, 1'b0, 8'h5a);
    d = io_rdata;
  endtask

  // read-modify-write keeps reserved bits exactly as they were read
  task automatic io_rmw(input logic [9:0] a, input logic [7:0] keep, input logic [7:0] v);
    logic [7:0] r;
    io_read(a, r);
    io_write(a, (r & keep) | v);
  endtask
endmodule

// *** test/brc_regs_tb_top.sv ***
// self-checking testbench for the board reset and boot rom control registers
`timescale 1ns/100ps
module brc_regs_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic backplane_sysreset_in = 1'b0;
  logic panel_switch_in = 1'b0;
  logic boot_jumper_installed = 1'b0;
  logic [9:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic board_reset_req;
  logic backplane_sysreset_out;
  logic scsi_terminator_enable;
  logic com2_driver_select;
  logic onboard_flash_write_enable;
  logic socket_flash_write_enable;
  logic boot_rom_chip_select;
  logic [7:0] r;
  logic [7:0] vals [6] = '{8'h00, 8'h21, 8'h42, 8'h83, 8'hff, 8'h01};
  int failures = 0;
  int n_tests = 0;

  // 100 mhz clock
  always #5 clk = ~clk;

  // --------------------------------------------------------------------------
  // instances
  // --------------------------------------------------------------------------
  // short reset pulses keep the event windows small
  brc_regs #(.ADDR_W(10), .RESET_PULSE_CYCLES(2)) brc_regs_inst (
    .clk(clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .backplane_sysreset_in(backplane_sysreset_in),
    .panel_switch_in(panel_switch_in), .boot_jumper_installed(boot_jumper_installed),
    .board_reset_req(board_reset_req), .backplane_sysreset_out(backplane_sysreset_out),
    .scsi_terminator_enable(scsi_terminator_enable), .com2_driver_select(com2_driver_select),
    .onboard_flash_write_enable(onboard_flash_write_enable),
    .socket_flash_write_enable(socket_flash_write_enable),
    .boot_rom_chip_select(boot_rom_chip_select)
  );

  brc_host_model brc_host_model_inst (
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .clk(clk), .io_rdata(io_rdata)
  );

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // option pins packed in register bit order of interest
  function automatic logic [7:0] pins();
    return {3'b000, scsi_terminator_enable, com2_driver_select, onboard_flash_write_enable,
      socket_flash_write_enable, boot_rom_chip_select};
  endfunction

  // raise one reset source and count cycles each output request stays high
  task automatic reset_event(input logic panel, input int exp_b, input int exp_p);
    int nb;
    int np;
    nb = 0;
    np = 0;
    @(posedge clk);
    #1;
    if (panel) begin
      panel_switch_in = 1'b1;
    end else begin
      backplane_sysreset_in = 1'b1;
    end
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      #1;
      nb += (board_reset_req === 1'b1);
      np += (backplane_sysreset_out === 1'b1);
    end
    panel_switch_in = 1'b0;
    backplane_sysreset_in = 1'b0;
    repeat (4) @(posedge clk);
    chk(8'(nb), 8'(exp_b));
    chk(8'(np), 8'(exp_p));
  endtask

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  // watchdog: a hang counts as a failure
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(pins(), 8'h11);
    brc_host_model_inst.io_read(10'h2a0, r);
    chk(r & 8'h11, 8'h01);
    brc_host_model_inst.io_read(10'h2a1, r);
    chk(r & 8'he3, 8'h81);
    // every option bit both ways; last value leaves flash writes shut
    foreach (vals[i]) begin
      brc_host_model_inst.io_write(10'h2a1, vals[i]);
      chk(pins(), {3'b000, vals[i][0], vals[i][1], vals[i][5], vals[i][6], vals[i][7]});
      brc_host_model_inst.io_read(10'h2a1, r);
      chk(r & 8'he3, vals[i] & 8'he3);
    end
    // unmapped neighbour must not alias onto the options register
    brc_host_model_inst.io_write(10'h2a2, 8'hff);
    brc_host_model_inst.io_read(10'h2a2, r);
    chk(r, 8'h00);
    brc_host_model_inst.io_read(10'h2a1, r);
    chk(r & 8'he3, 8'h01);
    brc_host_model_inst.io_rmw(10'h2a0, 8'hee, 8'h00);
    reset_event(1'b0, 0, 0);
    brc_host_model_inst.io_rmw(10'h2a0, 8'hee, 8'h01);
    reset_event(1'b0, 2, 0);
    reset_event(1'b1, 2, 0);
    brc_host_model_inst.io_rmw(10'h2a0, 8'hee, 8'h11);
    reset_event(1'b1, 2, 2);
    brc_host_model_inst.io_read(10'h2a0, r);
    chk(r & 8'h11, 8'h11);
    brc_host_model_inst.io_rmw(10'h2a0, 8'hee, 8'h10);
    reset_event(1'b0, 0, 0);
    // mid-run board reset with the jumper fitted: registers fall back, boot select follows the strap
    @(posedge clk);
    #1;
    boot_jumper_installed = 1'b1;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(pins(), 8'h11);
    @(posedge clk);
    #1;
    chk(pins(), 8'h10);
    brc_host_model_inst.io_read(10'h2a0, r);
    chk(r & 8'h11, 8'h01);
    brc_host_model_inst.io_read(10'h2a1, r);
    chk(r & 8'he3, 8'h01);
    test_done();
  end
endmodule
